// ---- dv/jla_align_props.sv ----
// assertion checker for the alignment block
`timescale 1ns/10ps
`default_nettype none
`include "jla_consts.vh"
module jla_align_props #(parameter DIV_W = 4) (
   // clock and reset
   input wire logic              clk,
   input wire logic              reset,
   // register port
   input wire logic [11:0]       reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata_ff,
   // reference and timing
   input wire logic              sysref,
   input wire logic              sysref_fall,
   input wire logic              frame_tick_ff,
   input wire logic              mf_tick_ff,
   input wire logic              div_sync_ff,
   input wire logic              aligned_ff,
   input wire logic [DIV_W-1:0]  sample_div_ff
);
   logic [1:0] rc_ff;
   logic [2:0] sc_ff;
   wire        pol = rc_ff[1];
   wire        sel = rc_ff[0] ? sysref_fall : sysref;
   // mirror of software settings, so checks follow them
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rc_ff <= 2'h0;
         sc_ff <= `JLA_SC_ONE;
      end else if (reg_wr && reg_addr == `JLA_OFF_REF_CTRL) begin
         rc_ff <= reg_wdata[4:3];
      end else if (reg_wr && reg_addr == `JLA_OFF_SUBCLASS) begin
         sc_ff <= reg_wdata[7:5];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_idle; !reg_rd |=> reg_rdata_ff == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_sc_rb; reg_rd && reg_addr == 12'h590 |=> reg_rdata_ff == {sc_ff, 5'h00}; endproperty
   a_sc_rb: assert property (p_sc_rb) else $error("subclass readback");
   property p_mon; reg_rd && reg_addr == 12'h128 |=> reg_rdata_ff[7:6] == 2'h0; endproperty
   a_mon: assert property (p_mon) else $error("monitor upper bits");
   property p_div0; div_sync_ff |-> sample_div_ff == 0 ##1 sample_div_ff == 1; endproperty
   a_div0: assert property (p_div0) else $error("divider not restarted");
   property p_cause;
      div_sync_ff |-> $past(sel, 3) != $past(pol, 2) && $past(sel, 4) == $past(pol, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("sync without event");
   property p_resp;
      (sel != pol && $past(sel) == pol) ##1 (sc_ff == 3'h1 && pol == $past(pol)) |-> ##2 div_sync_ff;
   endproperty
   a_resp: assert property (p_resp) else $error("event not taken");
   property p_gate; div_sync_ff |-> $past(sc_ff, 2) == 3'h1; endproperty
   a_gate: assert property (p_gate) else $error("sync outside subclass one");
   property p_al0; sc_ff == 3'h0 && $past(sc_ff) == 3'h0 |-> aligned_ff; endproperty
   a_al0: assert property (p_al0) else $error("not aligned in subclass zero");
   c_sync: cover property (div_sync_ff);
   c_mf: cover property (mf_tick_ff);
   c_al0: cover property (sc_ff == 3'h0 && aligned_ff);
endmodule // jla_align_props
`default_nettype wire

// ---- dv/jla_align_test.sv ----
// self-checking bench for the alignment block
`timescale 1ns/10ps
`default_nettype none
module jla_align_test;
   logic        clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, d, rdata, exp_q[$];
   logic        ref_lvl = 1'b0, rd_d = 1'b0, sysref, sysref_fall, fr_t, mf_t, sync, algn, go;
   logic [3:0]  div;
   int          miscompares = 0, cmp_count = 0, n, t0, t1, i, st, fc;
   int          fv[3] = '{1, 2, 4};
   int          ov[3] = '{6, 5, 3};
   always #12.5 clk = ~clk;
   jla_ref_src i_src (.clk(clk), .lvl(ref_lvl), .mf_tick(mf_t), .sysref(sysref),
      .sysref_fall(sysref_fall), .buf_go(go));
   jla_align #(.DIV_W(4)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
      .sysref(sysref), .sysref_fall(sysref_fall), .frame_tick_ff(fr_t), .mf_tick_ff(mf_t),
      .div_sync_ff(sync), .aligned_ff(algn), .sample_div_ff(div));
   task automatic test_done;
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one strobe cycle, then an idle edge so strobes never double-assign
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= v;
      if (!w) exp_q.push_back(v);
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   task automatic wt(input logic s, output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
         if (fr_t === 1'b1) fc++;
      end while ((s ? mf_t : sync) !== 1'b1 && c < 80);
   endtask
   task automatic fire(input logic p);
      @(posedge clk);
      ref_lvl <= p;
      repeat (5) @(posedge clk);
      ref_lvl <= !p;
      wt(1'b0, n);
   endtask
   task automatic mf(output int t);
      fire(1'b0);
      wt(1'b1, t);
      chk({7'h00, fr_t}, 8'h01);
      fc = 0;
      wt(1'b1, n);
      chk(8'(fc), 8'd8);
   endtask
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) chk(rdata, exp_q.pop_front());
   end
   initial begin
      void'($urandom(75));
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      bus(1'b0, 12'h120, 8'h00);
      bus(1'b0, 12'h578, 8'h00);
      bus(1'b0, 12'h590, 8'h20);
      bus(1'b0, 12'h5a0, 8'h01);
      bus(1'b0, 12'h5a8, 8'h1f);
      bus(1'b1, 12'h004, 8'hff);
      bus(1'b0, 12'h004, 8'h00);
      for (i = 0; i < 4; i++) begin
         d = 8'($urandom);
         bus(1'b1, 12'h578, d);
         bus(1'b0, 12'h578, d & 8'h1f);
         bus(1'b1, 12'h590, d);
         bus(1'b0, 12'h590, d & 8'he0);
      end
      bus(1'b1, 12'h590, 8'h20);
      bus(1'b1, 12'h578, 8'h00);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, 12'h120, 8'(i << 3));
         fire(i[1]);
         chk(8'(n), 8'd4);
         chk({4'h0, div}, 8'h00);
      end
      bus(1'b0, 12'h128, 8'h0f);
      bus(1'b1, 12'h128, 8'hff);
      bus(1'b0, 12'h128, 8'h0f);
      bus(1'b0, 12'h5a4, 8'h01);
      bus(1'b1, 12'h120, 8'h00);
      bus(1'b1, 12'h5a8, 8'h07);
      for (i = 0; i < 3; i++) begin
         bus(1'b1, 12'h5a0, 8'(fv[i]));
         bus(1'b1, 12'h578, 8'h00);
         mf(t0);
         chk(8'(n), 8'(8 * fv[i]));
         bus(1'b1, 12'h578, 8'(ov[i]));
         mf(t1);
         st = (fv[i] == 1 ? ov[i] / 4 : fv[i] == 2 ? ov[i] / 2 : ov[i]) * fv[i];
         chk(8'((t1 - t0 + 8 * fv[i]) % (8 * fv[i])), 8'(st));
      end
      bus(1'b1, 12'h590, 8'($urandom) & 8'h1f);
      bus(1'b0, 12'h590, 8'h00);
      fire(1'b0);
      chk(8'(n), 8'd80);
      chk({7'h00, algn}, 8'h01);
      bus(1'b0, 12'h5a4, 8'h00);
      chk({7'h00, go}, 8'h01);
      test_done;
   end
   // whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done;
   end
endmodule // jla_align_test
bind jla_align jla_align_props #(.DIV_W(DIV_W)) i_props (.clk(clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_ff(reg_rdata_ff), .sysref(sysref), .sysref_fall(sysref_fall),
   .frame_tick_ff(frame_tick_ff), .mf_tick_ff(mf_tick_ff), .div_sync_ff(div_sync_ff),
   .aligned_ff(aligned_ff), .sample_div_ff(sample_div_ff));
`default_nettype wire

// ---- dv/jla_ref_src.sv ----
// reference source and receiver buffer start
`timescale 1ns/10ps
`default_nettype none
module jla_ref_src (
   // clock, wanted level, multiframe tick
   input  wire logic clk,
   input  wire logic lvl,
   input  wire logic mf_tick,
   // reference pin at both clock edges, and buffer start
   output logic      sysref,
   output logic      sysref_fall,
   output logic      buf_go
);
   assign sysref = lvl;
   initial sysref_fall = 1'b0;
   always @(negedge clk) sysref_fall <= sysref;
   // buffer only ever starts on a multiframe edge
   initial buf_go = 1'b0;
   always @(posedge clk) if (mf_tick) buf_go <= 1'b1;
endmodule // jla_ref_src
`default_nettype wire

// ---- rtl/jla_align.v ----
// multiframe clock alignment to the system reference for the link transmitter
// What this block does
// - subclass field bits 7:5, reset 001
// - subclass 0 needs no reference input
// - subclass 0 transmitter clock phase arbitrary
// - multiframe clock marks every multiframe start
// - subclass 1 reference realigns clocks, dividers
// - latency variation at most one multiframe
// - five-bit offset delays multiframe clock
// - offset step scales with octets per frame
// - polarity bit picks alignment transition
// - edge bit picks rising or falling capture
// - read-only setup/hold monitor register
// - polarity 0 rising level; edge 0 rising clock
// - monitor hold high nibble, setup low nibble
`timescale 1ns/10ps
`default_nettype none
`include "jla_consts.vh"
module jla_align #(
   parameter DIV_W = 4
) (
   // clock and reset
   input  wire                   clk,
   input  wire                   reset,
   // register port
   input  wire [`JLA_ADDR_W-1:0] reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata_ff,
   // system reference, plus its value a half period later
   input  wire                   sysref,
   input  wire                   sysref_fall,
   // timing outputs
   output reg                    frame_tick_ff,
   output reg                    mf_tick_ff,
   output reg                    div_sync_ff,
   output reg                    aligned_ff,
   output reg  [DIV_W-1:0]       sample_div_ff
);
   reg  [7:0] ref_ctrl_ff;
   reg  [7:0] mf_off_ff;
   reg  [7:0] subclass_ff;
   reg  [7:0] frame_cfg_ff;
   reg  [7:0] k_cfg_ff;
   reg        ref_q_ff;
   reg        ref_prev_ff;
   reg        ref_ev_ff;
   reg        ev_seen_ff;
   reg  [7:0] oct_cnt_ff;
   reg  [7:0] frm_cnt_ff;
   reg  [5:0] dly_cnt_ff;
   reg        dly_run_ff;
   reg        fr_end_d_ff;
   reg        mf_raw_ff;
   reg  [7:0] mon_ff;
   reg        mon_ld_ff;
   wire [7:0] taps;
   wire [2:0] subclass;
   wire       sc1;
   wire       ref_sel;
   wire       ref_edge;
   wire       oct_end;
   wire       frm_end;
   wire [5:0] dly_tgt;
   reg  [7:0] nxt_rdata;

   assign subclass = subclass_ff[`JLA_SUBCLASS_MSB:`JLA_SUBCLASS_LSB];
   assign sc1      = (subclass == `JLA_SC_ONE);
   // half-period sample comes from the pad as an ordinary input
   assign ref_sel  = ref_ctrl_ff[`JLA_EDGE_BIT] ? sysref_fall : sysref;
   // polarity 0 means low-to-high is the event
   assign ref_edge = ref_ctrl_ff[`JLA_POL_BIT] ? (ref_prev_ff & ~ref_q_ff)
                                              : (~ref_prev_ff & ref_q_ff);

   // offset step: f=1 four codes a frame, f=2 two codes, else one
   assign dly_tgt = (frame_cfg_ff == 8'h01) ? {3'h0, mf_off_ff[`JLA_OFFSET_MSB:2]} :
                    (frame_cfg_ff == 8'h02) ? {2'h0, mf_off_ff[`JLA_OFFSET_MSB:1]} :
                    {1'b0, mf_off_ff[`JLA_OFFSET_MSB:0]};

   assign oct_end = (oct_cnt_ff >= frame_cfg_ff - 8'h01);
   assign frm_end = oct_end & (frm_cnt_ff >= k_cfg_ff);

   // register writes
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_ctrl_ff  <= `JLA_RST_REF_CTRL;
         mf_off_ff    <= `JLA_RST_MF_OFFSET;
         subclass_ff  <= `JLA_RST_SUBCLASS;
         frame_cfg_ff <= `JLA_RST_FRAME_CFG;
         k_cfg_ff     <= `JLA_RST_K_CFG;
      end else if (reg_wr) begin
         if (reg_addr == `JLA_OFF_REF_CTRL) begin
            ref_ctrl_ff <= reg_wdata;
         end else if (reg_addr == `JLA_OFF_MF_OFFSET) begin
            mf_off_ff <= {3'h0, reg_wdata[`JLA_OFFSET_MSB:0]};
         end else if (reg_addr == `JLA_OFF_SUBCLASS) begin
            subclass_ff <= {reg_wdata[`JLA_SUBCLASS_MSB:`JLA_SUBCLASS_LSB], 5'h00};
         end else if (reg_addr == `JLA_OFF_FRAME_CFG) begin
            // zero octets would stall the counters
            frame_cfg_ff <= (reg_wdata == 8'h00) ? 8'h01 : reg_wdata;
         end else if (reg_addr == `JLA_OFF_K_CFG) begin
            k_cfg_ff <= reg_wdata;
         end
      end
   end

   // reference capture and event detect
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_q_ff    <= 1'b0;
         ref_prev_ff <= 1'b0;
         ref_ev_ff   <= 1'b0;
      end else begin
         ref_q_ff    <= ref_sel;
         ref_prev_ff <= ref_q_ff;
         // subclass 0 ignores the pin, so a floating input is harmless
         ref_ev_ff   <= ref_edge & sc1;
      end
   end

   // frame and multiframe counters, reset to common phase by the event
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         oct_cnt_ff    <= 8'h00;
         frm_cnt_ff    <= 8'h00;
         sample_div_ff <= {DIV_W{1'b0}};
         div_sync_ff   <= 1'b0;
         fr_end_d_ff   <= 1'b0;
         mf_raw_ff     <= 1'b0;
      end else begin
         div_sync_ff <= ref_ev_ff;
         if (ref_ev_ff) begin
            oct_cnt_ff    <= 8'h00;
            frm_cnt_ff    <= 8'h00;
            sample_div_ff <= {DIV_W{1'b0}};
            fr_end_d_ff   <= 1'b0;
            mf_raw_ff     <= 1'b0;
         end else begin
            // free running phase in subclass 0 is acceptable
            sample_div_ff <= sample_div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
            fr_end_d_ff   <= oct_end;
            mf_raw_ff     <= frm_end;
            if (oct_end) begin
               oct_cnt_ff <= 8'h00;
               frm_cnt_ff <= frm_end ? 8'h00 : frm_cnt_ff + 8'h01;
            end else begin
               oct_cnt_ff <= oct_cnt_ff + 8'h01;
            end
         end
      end
   end

   // offset delay, counted in frame ends after the raw boundary
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         dly_cnt_ff    <= 6'h00;
         dly_run_ff    <= 1'b0;
         mf_tick_ff    <= 1'b0;
         frame_tick_ff <= 1'b0;
      end else begin
         frame_tick_ff <= fr_end_d_ff;
         mf_tick_ff    <= 1'b0;
         if (ref_ev_ff) begin
            dly_run_ff <= 1'b0;
            dly_cnt_ff <= 6'h00;
         end else if (mf_raw_ff && dly_tgt == 6'h00) begin
            mf_tick_ff <= 1'b1;
         end else if (mf_raw_ff) begin
            // limitation: offset must stay below one multiframe
            dly_run_ff <= 1'b1;
            dly_cnt_ff <= 6'h00;
         end else if (dly_run_ff && fr_end_d_ff) begin
            if (dly_cnt_ff + 6'h01 == dly_tgt) begin
               mf_tick_ff <= 1'b1;
               dly_run_ff <= 1'b0;
            end
            dly_cnt_ff <= dly_cnt_ff + 6'h01;
         end
      end
   end

   // alignment flag: set by event or outside subclass 1; ev_seen_ff clears on a subclass register write unless an event comes in the same cycle
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ev_seen_ff <= 1'b0;
         aligned_ff <= 1'b0;
      end else begin
         if (ref_ev_ff) begin
            ev_seen_ff <= 1'b1;
         end else if (reg_wr && reg_addr == `JLA_OFF_SUBCLASS) begin
            ev_seen_ff <= 1'b0;
         end
         aligned_ff <= ev_seen_ff | ~sc1;
      end
   end

   // monitor: samples before and after the capture edge
   jla_mon_taps #(
      .DEPTH (8)
   ) u_taps (
      .clk     (clk),
      .reset   (reset),
      .sample  (ref_sel),
      .freeze  (ref_edge),
      .taps_ff (taps)
   );

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         mon_ld_ff <= 1'b0;
         mon_ff    <= 8'h00;
      end else begin
         // taps hold the new window only one cycle after the freeze
         mon_ld_ff <= ref_edge;
         if (mon_ld_ff) begin
            // taps[1:0] are after the edge, older taps are before it
            mon_ff[`JLA_MON_HOLD_MSB:`JLA_MON_HOLD_LSB]   <= {2'h0, taps[1:0]};
            mon_ff[`JLA_MON_SETUP_MSB:`JLA_MON_SETUP_LSB] <= taps[5:2];
         end
      end
   end

   // read decode
   always @* begin
      nxt_rdata = 8'h00;
      if (reg_addr == `JLA_OFF_REF_CTRL) begin
         nxt_rdata = ref_ctrl_ff;
      end else if (reg_addr == `JLA_OFF_REF_MON) begin
         nxt_rdata = mon_ff;
      end else if (reg_addr == `JLA_OFF_MF_OFFSET) begin
         nxt_rdata = mf_off_ff;
      end else if (reg_addr == `JLA_OFF_SUBCLASS) begin
         nxt_rdata = subclass_ff;
      end else if (reg_addr == `JLA_OFF_FRAME_CFG) begin
         nxt_rdata = frame_cfg_ff;
      end else if (reg_addr == `JLA_OFF_K_CFG) begin
         nxt_rdata = k_cfg_ff;
      end else if (reg_addr == `JLA_OFF_STATUS) begin
         nxt_rdata = {7'h00, ev_seen_ff};
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end
endmodule // jla_align
`default_nettype wire

// ---- rtl/jla_consts.vh ----
// constants for the multiframe clock alignment block
`ifndef JLA_CONSTS_VH
`define JLA_CONSTS_VH
`define JLA_ADDR_W            12
`define JLA_OFF_REF_CTRL      12'h120
`define JLA_OFF_REF_MON       12'h128
`define JLA_OFF_MF_OFFSET     12'h578
`define JLA_OFF_SUBCLASS      12'h590
`define JLA_OFF_FRAME_CFG     12'h5a0
`define JLA_OFF_STATUS        12'h5a4
`define JLA_RST_REF_CTRL      8'h00
`define JLA_RST_MF_OFFSET     8'h00
`define JLA_RST_SUBCLASS      8'h20
`define JLA_RST_FRAME_CFG     8'h01
`define JLA_RST_K_CFG         8'h1f
`define JLA_SUBCLASS_LSB      5
`define JLA_SUBCLASS_MSB      7
`define JLA_SC_ZERO           3'h0
`define JLA_SC_ONE            3'h1
`define JLA_POL_BIT           4
`define JLA_EDGE_BIT          3
`define JLA_OFFSET_MSB        4
`define JLA_MON_HOLD_MSB      7
`define JLA_MON_HOLD_LSB      4
`define JLA_MON_SETUP_MSB     3
`define JLA_MON_SETUP_LSB     0
`define JLA_OFF_K_CFG         12'h5a8
`endif

// ---- rtl/jla_mon_taps.v ----
// shift register of reference samples around the capture edge for the monitor
`timescale 1ns/10ps
`default_nettype none
module jla_mon_taps #(
   parameter DEPTH = 8
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset,
   // sample stream and freeze request
   input  wire             sample,
   input  wire             freeze,
   // captured window
   output reg  [DEPTH-1:0] taps_ff
);
   reg [DEPTH-1:0] hist_ff;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         hist_ff <= {DEPTH{1'b0}};
         taps_ff <= {DEPTH{1'b0}};
      end else begin
         hist_ff <= {hist_ff[DEPTH-2:0], sample};
         if (freeze) begin
            taps_ff <= {hist_ff[DEPTH-2:0], sample};
         end
      end
   end
endmodule // jla_mon_taps
`default_nettype wire
